/* bench/error_source_model.sv */
`timescale 1ns/10ps
// ==========================================
// Error detector stand-in: one event per fire (none for kind 8, two for kind 9), pins idle high
module error_source_model
(
    input wire logic i_core_clk,
    input wire logic i_fire,
    input wire logic [3:0] i_kind,
    input wire logic [31:0] i_noise,
    output logic o_init_n,
    output logic o_ext_err_n,
    output system_bus_error_pkg::bus_cycle_t o_cycle,
    output system_bus_error_pkg::strobe_parity_events_t o_strobe
);
    logic [3:0] k;
    assign k = i_fire ? i_kind : 4'hf;
    initial
    begin
        o_init_n = 1'b1;
        o_ext_err_n = 1'b1;
        o_cycle = '0;
        o_strobe = '0;
    end
    // Pins drop for one cycle only, so each fire is exactly one falling edge
    always @(posedge i_core_clk)
    begin
        o_init_n <= (k != 4'd7);
        o_ext_err_n <= (k != 4'd6);
        o_cycle.valid <= (k == 4'd4) || (k == 4'd5) || (k == 4'd8);
        o_cycle.locked <= (k == 4'd5) || (k == 4'd8);
        o_cycle.decodes_dram <= (k == 4'd8);
        // Kind 8 lands above the boundary yet below 4 GB: must not log
        o_cycle.address <= (k == 4'd4) ? {4'h8, i_noise} :
            {4'h0, (k == 4'd8) ? 4'hf : 4'h0, i_noise[27:0]};
        o_strobe.address_strobe_glitch <= (k == 4'd2);
        o_strobe.data_strobe_glitch <= (k == 4'd1);
        o_strobe.data_parity <= (k == 4'd3) || (k == 4'd9);
        o_strobe.request_address_parity <= (k == 4'd0) || (k == 4'd9);
    end
endmodule : error_source_model

/* bench/system_bus_error_log_tb.sv */
`timescale 1ns/10ps
module system_bus_error_log_tb;
    logic i_core_clk, i_resetn, rd_en, wr_en, ws_q, fire, sci, smi, serr, irq, ws;
    logic [9:0] addr;
    logic [31:0] wdata, rdata, rd_q, noise, seed;
    logic [3:0] kind, be;
    logic [7:0] hub_first, hub_next, exp_first, exp_next, v, exp_irq;
    logic init_n, ext_n;
    system_bus_error_pkg::bus_cycle_t cyc;
    system_bus_error_pkg::strobe_parity_events_t sp;
    logic [7:0] en_idx [3];
    int err_total, comparisons;
    localparam logic [7:0] FIRST = system_bus_error_pkg::IDX_FIRST_ERROR_LOG;
    localparam logic [7:0] NEXT = system_bus_error_pkg::IDX_NEXT_ERROR_LOG;
    localparam logic [7:0] HUB = system_bus_error_pkg::IDX_HUB_A_SERR_ENABLE;

    system_bus_error_log uut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(ws), .i_bus_init_error_signal_n(init_n),
        .i_processor_external_error_signal_n(ext_n), .i_bus_cycle(cyc),
        .i_last_row_boundary(36'h0_8000_0000), .i_strobe_parity(sp),
        .i_hub_a_first_error_log(hub_first), .i_hub_a_next_error_log(hub_next),
        .o_sci(sci), .o_smi(smi), .o_serr(serr), .o_irq(irq));
    error_source_model partner (.i_core_clk(i_core_clk), .i_fire(fire), .i_kind(kind),
        .i_noise(noise), .o_init_n(init_n), .o_ext_err_n(ext_n), .o_cycle(cyc),
        .o_strobe(sp));

    // ==========================================
    // Clock and mid-cycle copies of what the rising edge samples
    initial
    begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    always @(negedge i_core_clk)
    begin
        ws_q <= ws;
        rd_q <= rdata;
    end

    // ==========================================
    // Helpers
    function logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand
    task check8(input string name, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : check8
    task check1(input string name, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %b seen %b", name, e, g);
        end
    endtask : check1
    task results;
        $display("Mismatches %0d of %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    // Request held until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        addr <= {idx, 2'b00};
        rd_en <= !w;
        wr_en <= w;
        wdata <= {24'h0, d};
        @(posedge i_core_clk);
        while (ws_q !== 1'b0)
        begin
            @(posedge i_core_clk);
            n++;
        end
        check1("wait_states", 1'b1, n == 1);
        r = rd_q[7:0];
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge i_core_clk);
    endtask : bus
    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, idx, d, r);
    endtask : wr
    task rdchk(input string name, input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] r;
        bus(1'b0, idx, 8'h00, r);
        check8(name, e, r);
    endtask : rdchk
    task msgs(input logic e_sci, input logic e_smi, input logic e_serr);
        @(negedge i_core_clk);
        check1("sci", e_sci, sci);
        check1("smi", e_smi, smi);
        check1("serr", e_serr, serr);
        @(posedge i_core_clk);
    endtask : msgs
    // Expected logs: highest simultaneous bit goes first, the rest accumulate next
    task fire_kind(input logic [3:0] k);
        logic [7:0] m, hi;
        m = (k == 4'd9) ? 8'h09 : (k == 4'd8) ? 8'h00 : 8'h01 << k;
        hi = (k == 4'd9) ? 8'h08 : m;
        if (m != 8'h00 && exp_first == 8'h00)
        begin
            exp_first = hi;
            exp_next |= m & ~hi;
            exp_irq = exp_irq | 8'h01 | (((m & ~hi) != 8'h00) ? 8'h02 : 8'h00);
        end
        else
        begin
            exp_next |= m;
            exp_irq = exp_irq | ((m != 8'h00) ? 8'h02 : 8'h00);
        end
        fire <= 1'b1;
        kind <= k;
        noise <= next_rand();
        @(posedge i_core_clk);
        fire <= 1'b0;
        repeat (4) @(posedge i_core_clk);
    endtask : fire_kind
    task clear_all;
        wr(FIRST, 8'hff);
        wr(NEXT, 8'hff);
        rdchk("irq_status", system_bus_error_pkg::IDX_IRQ_STATUS, exp_irq);
        exp_first = 8'h00;
        exp_next = 8'h00;
        exp_irq = 8'h00;
    endtask : clear_all

    // ==========================================
    // Watchdog: whole run is under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        check1("watchdog", 1'b0, 1'b1);
        results;
    end

    // ==========================================
    // Scenarios
    initial
    begin
        {rd_en, wr_en, fire, i_resetn} = '0;
        {addr, wdata, kind, hub_first, hub_next, noise} = '0;
        {err_total, comparisons} = '0;
        {be, exp_irq} = {4'hf, 8'h00};
        seed = 32'd44791;
        en_idx = '{system_bus_error_pkg::IDX_SCI_ENABLE, system_bus_error_pkg::IDX_SMI_ENABLE,
            system_bus_error_pkg::IDX_SERR_ENABLE};
        repeat (5) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        @(posedge i_core_clk);
        foreach (en_idx[i]) rdchk("enable_reset", en_idx[i], 8'h00);
        rdchk("first_reset", FIRST, 8'h00);
        rdchk("next_reset", NEXT, 8'h00);
        wr(8'h10, 8'hff);
        rdchk("unmapped", 8'h10, 8'h00);
        be <= 4'he;
        wr(en_idx[0], 8'hff);
        be <= 4'hf;
        rdchk("lane0_off", en_idx[0], 8'h00);
        foreach (en_idx[i])
        begin
            v = 8'(next_rand());
            wr(en_idx[i], v);
            rdchk("enable_rw", en_idx[i], v);
            wr(en_idx[i], 8'h00);
        end
        wr(HUB, 8'hff);
        rdchk("hub_enable", HUB, 8'h51);
        wr(HUB, 8'h00);
        // Each flag routed to exactly one message kind, rotating over the three
        for (int b = 0; b < 8; b++)
        begin
            clear_all;
            wr(en_idx[b % 3], 8'h01 << b);
            fire_kind(4'(b));
            rdchk("first_bit", FIRST, 8'h01 << b);
            rdchk("next_bit", NEXT, 8'h00);
            msgs(b % 3 == 0, b % 3 == 1, b % 3 == 2);
            wr(en_idx[b % 3], ~(8'h01 << b));
            msgs(1'b0, 1'b0, 1'b0);
            wr(en_idx[b % 3], 8'h00);
            wr(FIRST, 8'h00);
            rdchk("zero_write", FIRST, 8'h01 << b);
            wr(FIRST, 8'h01 << b);
            rdchk("w1c", FIRST, 8'h00);
        end
        clear_all;
        fire_kind(3);
        fire_kind(0);
        fire_kind(2);
        fire_kind(3);
        rdchk("first_frozen", FIRST, 8'h08);
        rdchk("next_accum", NEXT, 8'h0d);
        wr(NEXT, 8'h04);
        rdchk("next_w1c", NEXT, 8'h09);
        exp_next = 8'h09;
        wr(FIRST, 8'h08);
        exp_first = 8'h00;
        fire_kind(1);
        rdchk("first_resumed", FIRST, 8'h02);
        clear_all;
        fire_kind(9);
        rdchk("first_pair", FIRST, 8'h08);
        rdchk("next_pair", NEXT, 8'h01);
        clear_all;
        fire_kind(8);
        rdchk("no_event", FIRST, 8'h00);
        // Interrupt: raise, clear by read, then masked
        wr(system_bus_error_pkg::IDX_IRQ_MASK, 8'h03);
        fire_kind(5);
        check1("irq_on", 1'b1, irq);
        rdchk("irq_status", system_bus_error_pkg::IDX_IRQ_STATUS, 8'h01);
        exp_irq = 8'h00;
        msgs(1'b0, 1'b0, 1'b0);
        check1("irq_off", 1'b0, irq);
        wr(system_bus_error_pkg::IDX_IRQ_MASK, 8'h00);
        fire_kind(4);
        check1("irq_masked", 1'b0, irq);
        rdchk("irq_next", system_bus_error_pkg::IDX_IRQ_STATUS, 8'h02);
        exp_irq = 8'h00;
        // Hub interface levels against its own enable
        clear_all;
        hub_first <= 8'h10;
        wr(HUB, 8'h10);
        msgs(1'b0, 1'b0, 1'b1);
        wr(HUB, 8'h01);
        msgs(1'b0, 1'b0, 1'b0);
        hub_first <= 8'h00;
        hub_next <= 8'h41;
        wr(HUB, 8'h40);
        msgs(1'b0, 1'b0, 1'b1);
        wr(HUB, 8'h00);
        // Random traffic with occasional first-log acknowledge
        for (int i = 0; i < 30; i++)
        begin
            fire_kind(4'(next_rand() % 10));
            rdchk("rand_first", FIRST, exp_first);
            rdchk("rand_next", NEXT, exp_next);
            if (next_rand() % 3 == 0)
            begin
                wr(FIRST, exp_first);
                exp_first = 8'h00;
            end
        end
        results;
    end
endmodule : system_bus_error_log_tb

/* inc/system_bus_error_pkg.sv */
package system_bus_error_pkg;

    // ==========================================
    // Bus geometry
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FLAG_W = 8;
    localparam int unsigned SYS_ADDR_W = 36;

    // ==========================================
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_HUB_A_SERR_ENABLE = 8'h5c;
    localparam logic [7:0] IDX_FIRST_ERROR_LOG = 8'h60;
    localparam logic [7:0] IDX_NEXT_ERROR_LOG = 8'h62;
    localparam logic [7:0] IDX_SCI_ENABLE = 8'h68;
    localparam logic [7:0] IDX_SMI_ENABLE = 8'h6a;
    localparam logic [7:0] IDX_SERR_ENABLE = 8'h6c;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h71;

    // ==========================================
    // Reset values and field layouts
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [7:0] HUB_A_ENABLE_WRITABLE = 8'h51;
    localparam int unsigned BIT_BUS_INIT = 7;
    localparam int unsigned BIT_EXTERNAL_ERROR = 6;
    localparam int unsigned BIT_LOCK_OUTSIDE_DRAM = 5;
    localparam int unsigned BIT_ABOVE_MEMORY_TOP = 4;
    localparam int unsigned BIT_DATA_PARITY = 3;
    localparam int unsigned BIT_ADDRESS_STROBE_GLITCH = 2;
    localparam int unsigned BIT_DATA_STROBE_GLITCH = 1;
    localparam int unsigned BIT_REQUEST_PARITY = 0;
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_FIRST_CAPTURED = 0;
    localparam int unsigned IRQ_NEXT_ADDED = 1;
    localparam logic [35:0] FOUR_GB = 36'h1_0000_0000;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic address_strobe_glitch;
        logic data_strobe_glitch;
        logic data_parity;
        logic request_address_parity;
    } strobe_parity_events_t;

    typedef struct packed {
        logic valid;
        logic locked;
        logic decodes_dram;
        logic [35:0] address;
    } bus_cycle_t;

    function automatic logic [9:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

endpackage : system_bus_error_pkg

/* rtl/system_bus_error_log.sv */
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
module system_bus_error_log
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [system_bus_error_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [system_bus_error_pkg::DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [system_bus_error_pkg::DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_bus_init_error_signal_n,
    input wire logic i_processor_external_error_signal_n,
    input wire system_bus_error_pkg::bus_cycle_t i_bus_cycle,
    input wire logic [system_bus_error_pkg::SYS_ADDR_W-1:0] i_last_row_boundary,
    input wire system_bus_error_pkg::strobe_parity_events_t i_strobe_parity,
    input wire logic [7:0] i_hub_a_first_error_log,
    input wire logic [7:0] i_hub_a_next_error_log,
    output logic o_sci,
    output logic o_smi,
    output logic o_serr,
    output logic o_irq
);

    // ==========================================
    // Error detection
    logic bus_init_prev_n;
    logic external_prev_n;
    logic [7:0] events;
    logic above_top;

    // Pins idle high; reset to the idle level so release is not an edge
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            bus_init_prev_n <= 1'b1;
            external_prev_n <= 1'b1;
        end
        else
        begin
            bus_init_prev_n <= i_bus_init_error_signal_n;
            external_prev_n <= i_processor_external_error_signal_n;
        end
    end

    assign above_top = (i_bus_cycle.address > i_last_row_boundary)
        && (i_bus_cycle.address >= system_bus_error_pkg::FOUR_GB);

    always_comb
    begin
        events = 8'h00;
        events[system_bus_error_pkg::BIT_BUS_INIT] =
            bus_init_prev_n & ~i_bus_init_error_signal_n;
        events[system_bus_error_pkg::BIT_EXTERNAL_ERROR] =
            external_prev_n & ~i_processor_external_error_signal_n;
        events[system_bus_error_pkg::BIT_LOCK_OUTSIDE_DRAM] =
            i_bus_cycle.valid & i_bus_cycle.locked & ~i_bus_cycle.decodes_dram;
        events[system_bus_error_pkg::BIT_ABOVE_MEMORY_TOP] =
            i_bus_cycle.valid & above_top;
        events[system_bus_error_pkg::BIT_DATA_PARITY] =
            i_strobe_parity.data_parity;
        events[system_bus_error_pkg::BIT_ADDRESS_STROBE_GLITCH] =
            i_strobe_parity.address_strobe_glitch;
        events[system_bus_error_pkg::BIT_DATA_STROBE_GLITCH] =
            i_strobe_parity.data_strobe_glitch;
        events[system_bus_error_pkg::BIT_REQUEST_PARITY] =
            i_strobe_parity.request_address_parity;
    end

    // ==========================================
    // Bus slave: one wait state, then accept
    logic ack;
    logic accept;
    logic wr_accept;
    logic rd_accept;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            ack <= 1'b0;
        end
        else
        begin
            ack <= (i_avs_read | i_avs_write) & ~ack;
        end
    end

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
    assign accept = (i_avs_read | i_avs_write) & ack;
    assign wr_accept = accept & i_avs_write & i_avs_byteenable[0];
    assign rd_accept = accept & i_avs_read;

    function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
        hit = (a == system_bus_error_pkg::byte_addr(idx));
    endfunction : hit

    // ==========================================
    // Error logs
    logic [7:0] first_log;
    logic [7:0] next_log;
    logic [7:0] first_set;
    logic [7:0] next_set;
    logic [7:0] first_clr;
    logic [7:0] next_clr;

    // Simultaneous errors: most severe (highest bit) is the first one
    function automatic logic [7:0] top_bit(input logic [7:0] v);
        top_bit = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (v[i])
            begin
                top_bit = 8'h01 << i;
            end
        end
    endfunction : top_bit

    assign first_set = (first_log == 8'h00) ? top_bit(events) : 8'h00;
    assign next_set = events & ~first_set;
    assign first_clr = (wr_accept && hit(i_avs_address,
        system_bus_error_pkg::IDX_FIRST_ERROR_LOG)) ? i_avs_writedata[7:0] : 8'h00;
    assign next_clr = (wr_accept && hit(i_avs_address,
        system_bus_error_pkg::IDX_NEXT_ERROR_LOG)) ? i_avs_writedata[7:0] : 8'h00;

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            first_log <= system_bus_error_pkg::FLAGS_RESET;
        end
        else
        begin
            first_log <= (first_log & ~first_clr) | first_set;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            next_log <= system_bus_error_pkg::FLAGS_RESET;
        end
        else
        begin
            next_log <= (next_log & ~next_clr) | next_set;
        end
    end

    // ==========================================
    // Enable registers
    logic [7:0] sci_enable;
    logic [7:0] smi_enable;
    logic [7:0] serr_enable;
    logic [7:0] hub_a_serr_enable;
    logic [1:0] irq_mask;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            sci_enable <= system_bus_error_pkg::ENABLE_RESET;
            smi_enable <= system_bus_error_pkg::ENABLE_RESET;
            serr_enable <= system_bus_error_pkg::ENABLE_RESET;
            hub_a_serr_enable <= system_bus_error_pkg::ENABLE_RESET;
            irq_mask <= system_bus_error_pkg::IRQ_RESET;
        end
        else if (wr_accept)
        begin
            if (hit(i_avs_address, system_bus_error_pkg::IDX_SCI_ENABLE))
            begin
                sci_enable <= i_avs_writedata[7:0];
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_SMI_ENABLE))
            begin
                smi_enable <= i_avs_writedata[7:0];
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_SERR_ENABLE))
            begin
                serr_enable <= i_avs_writedata[7:0];
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_HUB_A_SERR_ENABLE))
            begin
                hub_a_serr_enable <= i_avs_writedata[7:0]
                    & system_bus_error_pkg::HUB_A_ENABLE_WRITABLE;
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_IRQ_MASK))
            begin
                irq_mask <= i_avs_writedata[1:0];
            end
        end
    end

    // ==========================================
    // Message outputs
    logic [7:0] all_flags;
    logic [7:0] hub_flags;

    assign all_flags = first_log | next_log;
    assign hub_flags = i_hub_a_first_error_log | i_hub_a_next_error_log;

    // Overlapping enables give several messages; software must avoid that
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            o_sci <= 1'b0;
            o_smi <= 1'b0;
            o_serr <= 1'b0;
        end
        else
        begin
            o_sci <= |(all_flags & sci_enable);
            o_smi <= |(all_flags & smi_enable);
            o_serr <= |(all_flags & serr_enable)
                | |(hub_flags & hub_a_serr_enable);
        end
    end

    // ==========================================
    // Interrupt status, cleared by a read
    logic [1:0] irq_status;
    logic [1:0] irq_set;
    logic irq_rd;

    assign irq_set = {|next_set, |first_set};
    assign irq_rd = rd_accept && hit(i_avs_address, system_bus_error_pkg::IDX_IRQ_STATUS);

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            irq_status <= system_bus_error_pkg::IRQ_RESET;
            o_irq <= 1'b0;
        end
        else
        begin
            irq_status <= (irq_rd ? 2'h0 : irq_status) | irq_set;
            o_irq <= |(irq_status & irq_mask);
        end
    end

    // ==========================================
    // Read data, captured in the wait cycle so it stands at accept
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            o_avs_readdata <= 32'h0000_0000;
        end
        else if (i_avs_read && !ack)
        begin
            if (hit(i_avs_address, system_bus_error_pkg::IDX_FIRST_ERROR_LOG))
            begin
                o_avs_readdata <= {24'h00_0000, first_log};
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_NEXT_ERROR_LOG))
            begin
                o_avs_readdata <= {24'h00_0000, next_log};
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_SCI_ENABLE))
            begin
                o_avs_readdata <= {24'h00_0000, sci_enable};
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_SMI_ENABLE))
            begin
                o_avs_readdata <= {24'h00_0000, smi_enable};
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_SERR_ENABLE))
            begin
                o_avs_readdata <= {24'h00_0000, serr_enable};
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_HUB_A_SERR_ENABLE))
            begin
                o_avs_readdata <= {24'h00_0000, hub_a_serr_enable};
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_IRQ_STATUS))
            begin
                o_avs_readdata <= {30'h0, irq_status};
            end
            else if (hit(i_avs_address, system_bus_error_pkg::IDX_IRQ_MASK))
            begin
                o_avs_readdata <= {30'h0, irq_mask};
            end
            else
            begin
                o_avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    first_log_hold_a: assert property (
        (first_log != 8'h00) && (first_clr == 8'h00) |=> $stable(first_log))
        else $error("first log changed while holding a flag");

    first_one_bit_a: assert property (
        (first_log == 8'h00) && (events != 8'h00) |=> $onehot(first_log))
        else $error("first error not captured as one flag");

    next_gets_later_a: assert property (
        (first_log != 8'h00) |-> ##1 ((next_log & $past(events)) == $past(events)))
        else $error("later error missing from next log");

    zero_write_keeps_a: assert property (
        wr_accept && hit(i_avs_address, system_bus_error_pkg::IDX_NEXT_ERROR_LOG)
        |=> ((next_log & ~$past(i_avs_writedata[7:0])) == (($past(next_log)
            | $past(next_set)) & ~$past(i_avs_writedata[7:0]))))
        else $error("next log flag changed by a zero write");

    init_edge_a: assert property (
        $fell(i_bus_init_error_signal_n) |=> all_flags[system_bus_error_pkg::BIT_BUS_INIT])
        else $error("bus init edge not logged");

    external_edge_a: assert property (
        $fell(i_processor_external_error_signal_n)
        |=> all_flags[system_bus_error_pkg::BIT_EXTERNAL_ERROR])
        else $error("external error edge not logged");

    sci_follows_a: assert property (
        ##1 o_sci == $past(|(all_flags & sci_enable)))
        else $error("sci does not follow enabled flags");

    smi_masked_a: assert property (
        (smi_enable == 8'h00) ##1 (smi_enable == 8'h00) |-> !o_smi)
        else $error("smi raised with all enables zero");

    hub_serr_a: assert property (
        (hub_flags & hub_a_serr_enable) != 8'h00 |=> o_serr)
        else $error("hub interface serr missing");

    hub_reserved_a: assert property (
        wr_accept && hit(i_avs_address, system_bus_error_pkg::IDX_HUB_A_SERR_ENABLE)
        |=> hub_a_serr_enable == ($past(i_avs_writedata[7:0])
            & system_bus_error_pkg::HUB_A_ENABLE_WRITABLE))
        else $error("reserved hub enable bit set");

    wait_then_accept_a: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not accepted after one wait state");

    first_and_next_c: cover property (
        (first_log != 8'h00) ##[1:20] (next_log != 8'h00));
    clear_then_relog_c: cover property (
        (first_log != 8'h00) ##1 (first_log == 8'h00) ##[1:20] (first_log != 8'h00));
    serr_raised_c: cover property ($rose(o_serr));
    irq_raised_c: cover property ($rose(o_irq));

endmodule : system_bus_error_log
